//--- rtl/aec_pkg.sv
// Constants, field layouts and carrier types for the error-reporting register slice.
// Assumes a 12-bit configuration offset space reached by a plain strobe port.
// ============================================================================
// How it works
// - Unmasked ECRC error reports fatal when severity bit 19 set, else non-fatal; sticky.
// - Unmasked unsupported-request error uses severity bit 20 the same way; resets zero.
// - Receiver error sets correctable status bit 0; write one clears; resets zero.
// - Bad received packet sets correctable status bit 6; write one clears.
// - Bad link packet sets correctable status bit 7; write one clears.
// - Replay number rollover sets correctable status bit 8.
// - Replay timer expiry sets correctable status bit 12; write one clears.
// - Advisory non-fatal condition sets correctable status bit 13; write one clears.
// - A set correctable mask bit stops reporting of the matching status event.
// - Advisory non-fatal mask bit resets to one; other mask bits reset to zero.
// - Control bits 4:0 hold position of first reported uncorrectable error; read-only.
// - Control bit 5 shows CRC generation capable; resets one; write-locked.
// - Control bit 6 enables CRC generation on transmit; resets zero; sticky.
// - Control bit 7 shows CRC check capable; resets one; write-locked.
// - Control bit 8 enables CRC checking on receive; resets zero.
// - A masked uncorrectable event is neither logged nor reported.
package aec_pkg;

  typedef logic [11:0] aec_addr_t;
  typedef logic [31:0] aec_word_t;

  // ==========================================================================
  // Register offsets
  localparam aec_addr_t OFS_SEVERITY    = 12'h10C;
  localparam aec_addr_t OFS_CORR_STATUS = 12'h110;
  localparam aec_addr_t OFS_CORR_MASK   = 12'h114;
  localparam aec_addr_t OFS_CONTROL     = 12'h118;
  localparam aec_addr_t OFS_IRQ_STATUS  = 12'h130;
  localparam aec_addr_t OFS_IRQ_CLEAR   = 12'h134;
  localparam aec_addr_t OFS_IRQ_ENABLE  = 12'h138;

  // ==========================================================================
  // Field positions and reset values
  localparam int        SEV_ECRC_BIT      = 19;
  localparam int        SEV_UR_BIT        = 20;
  localparam aec_word_t SEV_IMPL          = 32'h0018_0000;
  localparam aec_word_t SEV_RESET         = 32'h0000_0000;
  localparam int        CORR_RCV_BIT      = 0;
  localparam int        CORR_TLP_BIT      = 6;
  localparam int        CORR_DLLP_BIT     = 7;
  localparam int        CORR_ROLL_BIT     = 8;
  localparam int        CORR_TMO_BIT      = 12;
  localparam int        CORR_ADV_BIT      = 13;
  localparam aec_word_t CORR_IMPL         = 32'h0000_31C1;
  localparam aec_word_t CORR_STATUS_RESET = 32'h0000_0000;
  localparam aec_word_t CORR_MASK_RESET   = 32'h0000_2000;
  localparam int        CTL_FEP_LSB       = 0;
  localparam int        CTL_FEP_W         = 5;
  localparam int        CTL_GEN_CAP       = 5;
  localparam int        CTL_GEN_EN        = 6;
  localparam int        CTL_CHK_CAP       = 7;
  localparam int        CTL_CHK_EN        = 8;
  localparam logic      CTL_CAP_RESET     = 1'b1;
  localparam logic      CTL_EN_RESET      = 1'b0;
  localparam logic [4:0] FEP_RESET        = 5'h00;
  localparam int        IRQ_W             = 3;
  localparam int        IRQ_CORR          = 0;
  localparam int        IRQ_NONFATAL      = 1;
  localparam int        IRQ_FATAL         = 2;
  localparam logic [2:0] IRQ_RESET        = 3'h0;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic advisory_nonfatal_flag;
    logic replay_timer_expired;
    logic replay_count_rollover;
    logic bad_link_packet_flag;
    logic bad_packet_flag;
    logic receiver_error_flag;
  } aec_corr_evt_s;

  typedef struct packed {
    aec_addr_t addr;
    aec_word_t wdata;
    logic      wr;
    logic      rd;
  } aec_bus_req_s;

  typedef struct packed {
    logic fatal;
    logic nonfatal;
    logic correctable;
  } aec_report_s;

endpackage : aec_pkg

//--- rtl/aec_top.sv
// Error-reporting register slice of one switch port: severity, correctable
// status and mask, control with first-error pointer and CRC enables.
// Assumes events arrive as one-cycle pulses synchronous to clk_sys and that a
// cold power-on reset is given separately from the ordinary reset.
`timescale 1ns/100ps

module aec_top
  import aec_pkg::*;
(
  input  wire logic          clk_sys,
  input  wire logic          reset,
  input  wire logic          cold_reset,
  input  wire aec_bus_req_s  bus_req,
  output aec_word_t          rd_data,
  input  wire aec_corr_evt_s corr_evt,
  input  wire logic          ecrc_err_evt,
  input  wire logic          ur_err_evt,
  input  wire logic          unc_mask_ecrc,
  input  wire logic          unc_mask_ur,
  input  wire logic          unc_log_clear,
  input  wire logic          cap_unlock,
  output aec_report_s        report,
  output logic               crc_generate_enable,
  output logic               crc_check_enable,
  output logic               irq
);

  // ==========================================================================
  // Address decode
  wire logic any_reset;
  wire logic wr_sev;
  wire logic wr_status;
  wire logic wr_mask;
  wire logic wr_ctl;
  wire logic wr_irq_clr;
  wire logic wr_irq_en;

  assign any_reset  = reset | cold_reset;
  assign wr_sev     = bus_req.wr && (bus_req.addr == OFS_SEVERITY);
  assign wr_status  = bus_req.wr && (bus_req.addr == OFS_CORR_STATUS);
  assign wr_mask    = bus_req.wr && (bus_req.addr == OFS_CORR_MASK);
  assign wr_ctl     = bus_req.wr && (bus_req.addr == OFS_CONTROL);
  assign wr_irq_clr = bus_req.wr && (bus_req.addr == OFS_IRQ_CLEAR);
  assign wr_irq_en  = bus_req.wr && (bus_req.addr == OFS_IRQ_ENABLE);

  // ==========================================================================
  // Correctable events mapped onto their status positions
  aec_word_t corr_set;
  aec_word_t corr_status_reg;
  aec_word_t corr_status_next;
  aec_word_t corr_mask_reg;
  aec_word_t corr_mask_next;

  always_comb begin
    corr_set                = '0;
    corr_set[CORR_RCV_BIT]  = corr_evt.receiver_error_flag;
    corr_set[CORR_TLP_BIT]  = corr_evt.bad_packet_flag;
    corr_set[CORR_DLLP_BIT] = corr_evt.bad_link_packet_flag;
    corr_set[CORR_ROLL_BIT] = corr_evt.replay_count_rollover;
    corr_set[CORR_TMO_BIT]  = corr_evt.replay_timer_expired;
    corr_set[CORR_ADV_BIT]  = corr_evt.advisory_nonfatal_flag;
  end

  // Per bit: an event in the clearing cycle wins, so no event is lost
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_status
      if (CORR_IMPL[gi]) begin : g_impl
        assign corr_status_next[gi] = corr_set[gi] |
               (corr_status_reg[gi] & ~(wr_status & bus_req.wdata[gi]));
        assign corr_mask_next[gi]   = wr_mask ? bus_req.wdata[gi] : corr_mask_reg[gi];
      end else begin : g_rsvd
        assign corr_status_next[gi] = 1'b0;
        assign corr_mask_next[gi]   = 1'b0;
      end
    end
  endgenerate

  // Status and mask are sticky: only the cold reset returns them
  always_ff @(posedge clk_sys) begin
    if (cold_reset) begin
      corr_status_reg <= CORR_STATUS_RESET;
      corr_mask_reg   <= CORR_MASK_RESET;
    end else begin
      corr_status_reg <= corr_status_next;
      corr_mask_reg   <= corr_mask_next;
    end
  end

  // ==========================================================================
  // Uncorrectable severity and first-error pointer
  aec_word_t  sev_reg;
  aec_word_t  sev_next;
  logic [4:0] fep_reg;
  logic [4:0] fep_next;
  logic       fep_armed_reg;
  logic       fep_armed_next;
  wire logic  fep_open;
  wire logic  ecrc_live;
  wire logic  ur_live;

  assign sev_next  = wr_sev ? (bus_req.wdata & SEV_IMPL) : sev_reg;
  // Masked uncorrectable events go nowhere, whatever the severity says
  assign ecrc_live = ecrc_err_evt & ~unc_mask_ecrc;
  assign ur_live   = ur_err_evt & ~unc_mask_ur;

  // Lower bit wins when both arrive together; an event beside the re-arm is captured
  assign fep_open       = fep_armed_reg | unc_log_clear;
  assign fep_next       = (fep_open & ecrc_live) ? 5'(SEV_ECRC_BIT) :
                          (fep_open & ur_live)   ? 5'(SEV_UR_BIT)   : fep_reg;
  assign fep_armed_next = fep_open & ~(ecrc_live | ur_live);

  always_ff @(posedge clk_sys) begin
    if (cold_reset) begin
      sev_reg       <= SEV_RESET;
      fep_reg       <= FEP_RESET;
      fep_armed_reg <= 1'b1;
    end else begin
      sev_reg       <= sev_next;
      fep_reg       <= fep_next;
      fep_armed_reg <= fep_armed_next;
    end
  end

  // ==========================================================================
  // Control register: capability bits are not sticky, enables are
  logic gen_cap_reg;
  logic chk_cap_reg;
  logic gen_en_reg;
  logic chk_en_reg;
  wire logic cap_wr;

  // Capabilities may only be trimmed while the lock is open
  assign cap_wr = wr_ctl & cap_unlock;

  always_ff @(posedge clk_sys) begin
    if (any_reset) begin
      gen_cap_reg <= CTL_CAP_RESET;
      chk_cap_reg <= CTL_CAP_RESET;
    end else if (cap_wr) begin
      gen_cap_reg <= bus_req.wdata[CTL_GEN_CAP];
      chk_cap_reg <= bus_req.wdata[CTL_CHK_CAP];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (cold_reset) begin
      gen_en_reg <= CTL_EN_RESET;
      chk_en_reg <= CTL_EN_RESET;
    end else if (wr_ctl) begin
      gen_en_reg <= bus_req.wdata[CTL_GEN_EN];
      chk_en_reg <= bus_req.wdata[CTL_CHK_EN];
    end
  end

  assign crc_generate_enable = gen_en_reg;
  assign crc_check_enable    = chk_en_reg;

  // ==========================================================================
  // Error reports to the root complex, one registered pulse per class for all events of one cycle
  aec_report_s report_reg;
  aec_report_s report_next;
  wire logic   corr_live;

  assign corr_live = |(corr_set & ~corr_mask_reg);

  always_comb begin
    report_next.correctable = corr_live;
    report_next.fatal       = (ecrc_live & sev_reg[SEV_ECRC_BIT]) |
                              (ur_live & sev_reg[SEV_UR_BIT]);
    report_next.nonfatal    = (ecrc_live & ~sev_reg[SEV_ECRC_BIT]) |
                              (ur_live & ~sev_reg[SEV_UR_BIT]);
  end

  always_ff @(posedge clk_sys) begin
    if (any_reset) begin
      report_reg <= '0;
    end else begin
      report_reg <= report_next;
    end
  end

  assign report = report_reg;

  // ==========================================================================
  // Interrupt status, write-only clear and read-write enable
  logic [2:0] irq_status_reg;
  logic [2:0] irq_status_next;
  logic [2:0] irq_en_reg;
  wire logic  [2:0] irq_clr;

  assign irq_clr         = wr_irq_clr ? bus_req.wdata[IRQ_W-1:0] : IRQ_RESET;
  // A report in the clearing cycle keeps its bit set
  assign irq_status_next = {report_reg.fatal, report_reg.nonfatal, report_reg.correctable} |
                           (irq_status_reg & ~irq_clr);

  always_ff @(posedge clk_sys) begin
    if (any_reset) begin
      irq_status_reg <= IRQ_RESET;
      irq_en_reg     <= IRQ_RESET;
    end else begin
      irq_status_reg <= irq_status_next;
      irq_en_reg     <= wr_irq_en ? bus_req.wdata[IRQ_W-1:0] : irq_en_reg;
    end
  end

  assign irq = |(irq_status_reg & irq_en_reg);

  // ==========================================================================
  // Read path: data one cycle after the strobe, unmapped offsets read zero
  aec_word_t ctl_word;
  aec_word_t rd_mux;
  aec_word_t rd_data_reg;

  always_comb begin
    ctl_word                                   = '0;
    ctl_word[CTL_FEP_LSB +: CTL_FEP_W]         = fep_reg;
    ctl_word[CTL_GEN_CAP]                      = gen_cap_reg;
    ctl_word[CTL_GEN_EN]                       = gen_en_reg;
    ctl_word[CTL_CHK_CAP]                      = chk_cap_reg;
    ctl_word[CTL_CHK_EN]                       = chk_en_reg;
  end

  assign rd_mux = (bus_req.addr == OFS_SEVERITY)    ? sev_reg         :
                  (bus_req.addr == OFS_CORR_STATUS) ? corr_status_reg :
                  (bus_req.addr == OFS_CORR_MASK)   ? corr_mask_reg   :
                  (bus_req.addr == OFS_CONTROL)     ? ctl_word        :
                  (bus_req.addr == OFS_IRQ_STATUS)  ? {29'h0000_0000, irq_status_reg} :
                  (bus_req.addr == OFS_IRQ_ENABLE)  ? {29'h0000_0000, irq_en_reg} :
                  32'h0000_0000;

  always_ff @(posedge clk_sys) begin
    if (any_reset) begin
      rd_data_reg <= '0;
    end else begin
      rd_data_reg <= bus_req.rd ? rd_mux : 32'h0000_0000;
    end
  end

  assign rd_data = rd_data_reg;

  // ==========================================================================
  // Assertions
  sequence s_ecrc_unmasked;
    ecrc_err_evt && !unc_mask_ecrc && !ur_err_evt;
  endsequence

  sequence s_ur_unmasked;
    ur_err_evt && !unc_mask_ur && !ecrc_err_evt;
  endsequence

  property p_ecrc_severity;
    @(posedge clk_sys) disable iff (any_reset)
    s_ecrc_unmasked |=> (report.fatal == $past(sev_reg[SEV_ECRC_BIT])) &&
                        (report.nonfatal != $past(sev_reg[SEV_ECRC_BIT]));
  endproperty
  a_ecrc_severity: assert property (p_ecrc_severity)
    else $error("ECRC error reported with wrong severity");

  property p_ur_severity;
    @(posedge clk_sys) disable iff (any_reset)
    s_ur_unmasked |=> (report.fatal == $past(sev_reg[SEV_UR_BIT])) &&
                      (report.nonfatal != $past(sev_reg[SEV_UR_BIT]));
  endproperty
  a_ur_severity: assert property (p_ur_severity)
    else $error("Unsupported request reported with wrong severity");

  property p_rcv_sets;
    @(posedge clk_sys) disable iff (any_reset)
    corr_evt.receiver_error_flag |=> corr_status_reg[CORR_RCV_BIT];
  endproperty
  a_rcv_sets: assert property (p_rcv_sets)
    else $error("Receiver error did not set its status bit");

  property p_w1c_clears;
    @(posedge clk_sys) disable iff (any_reset)
    (wr_status && bus_req.wdata[CORR_TLP_BIT] && !corr_evt.bad_packet_flag)
      |=> !corr_status_reg[CORR_TLP_BIT];
  endproperty
  a_w1c_clears: assert property (p_w1c_clears)
    else $error("Write one did not clear bad packet status");

  property p_status_holds;
    @(posedge clk_sys) disable iff (any_reset)
    (corr_status_reg[CORR_DLLP_BIT] && !(wr_status && bus_req.wdata[CORR_DLLP_BIT]))
      |=> corr_status_reg[CORR_DLLP_BIT];
  endproperty
  a_status_holds: assert property (p_status_holds)
    else $error("Bad link packet status dropped without a clear");

  property p_set_wins;
    @(posedge clk_sys) disable iff (any_reset)
    (corr_evt.replay_count_rollover && wr_status) |=> corr_status_reg[CORR_ROLL_BIT];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("Rollover lost against a clear");

  property p_timeout_sets;
    @(posedge clk_sys) disable iff (any_reset)
    corr_evt.replay_timer_expired |=> corr_status_reg[CORR_TMO_BIT];
  endproperty
  a_timeout_sets: assert property (p_timeout_sets)
    else $error("Replay timeout did not set its status bit");

  property p_adv_masked;
    @(posedge clk_sys) disable iff (any_reset)
    (corr_evt.advisory_nonfatal_flag && corr_mask_reg[CORR_ADV_BIT] &&
     ((corr_set & ~corr_mask_reg) == 32'h0000_0000))
      |=> corr_status_reg[CORR_ADV_BIT] && !report.correctable;
  endproperty
  a_adv_masked: assert property (p_adv_masked)
    else $error("Masked advisory error was reported or not logged");

  property p_corr_report;
    @(posedge clk_sys) disable iff (any_reset)
    report.correctable == $past(|(corr_set & ~corr_mask_reg));
  endproperty
  a_corr_report: assert property (p_corr_report)
    else $error("Correctable report disagrees with mask");

  property p_mask_reset;
    @(posedge clk_sys)
    $fell(cold_reset) |-> corr_mask_reg == CORR_MASK_RESET;
  endproperty
  a_mask_reset: assert property (p_mask_reset)
    else $error("Mask register left cold reset with wrong value");

  property p_fep_capture;
    @(posedge clk_sys) disable iff (any_reset)
    (fep_armed_reg ##0 s_ur_unmasked) |=> fep_reg == 5'(SEV_UR_BIT) ##1
      (fep_reg == 5'(SEV_UR_BIT) || fep_armed_reg || $past(fep_armed_reg) ||
       $past(unc_log_clear));
  endproperty
  a_fep_capture: assert property (p_fep_capture)
    else $error("First error pointer not captured");

  property p_caps_locked;
    @(posedge clk_sys) disable iff (any_reset)
    !cap_unlock |=> $stable(gen_cap_reg) && $stable(chk_cap_reg);
  endproperty
  a_caps_locked: assert property (p_caps_locked)
    else $error("Capability bit changed while locked");

  property p_en_sticky;
    @(posedge clk_sys) disable iff (cold_reset)
    reset |=> $stable(crc_generate_enable) && $stable(crc_check_enable);
  endproperty
  a_en_sticky: assert property (p_en_sticky)
    else $error("CRC enable lost on ordinary reset");

  property p_masked_silent;
    @(posedge clk_sys) disable iff (any_reset)
    (ecrc_err_evt && unc_mask_ecrc && !ur_live) |=>
      !report.fatal && !report.nonfatal && $stable(fep_reg);
  endproperty
  a_masked_silent: assert property (p_masked_silent)
    else $error("Masked uncorrectable event was logged or reported");

  property p_rsvd_zero;
    @(posedge clk_sys) disable iff (any_reset)
    ((corr_status_reg & ~CORR_IMPL) == 32'h0000_0000) && ((sev_reg & ~SEV_IMPL) == 32'h0000_0000);
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("Reserved bit holds a one");

endmodule : aec_top

//--- tb/aec_rc_model.sv
// Root complex stand-in: counts the error reports that the port sends upstream.
// Assumes report pulses are one cycle long and synchronous to clk_sys.
`timescale 1ns/100ps

module aec_rc_model
  import aec_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        cold_reset,
  input  wire aec_report_s report,
  output logic [7:0]       n_fatal,
  output logic [7:0]       n_nonfatal,
  output logic [7:0]       n_corr
);
  // ==========================================================================
  // Report tally
  // Cleared only by cold reset, so reports sent around an ordinary reset still count
  always_ff @(posedge clk_sys) begin
    if (cold_reset) begin
      n_fatal    <= '0;
      n_nonfatal <= '0;
      n_corr     <= '0;
    end else begin
      n_fatal    <= n_fatal + 8'(report.fatal);
      n_nonfatal <= n_nonfatal + 8'(report.nonfatal);
      n_corr     <= n_corr + 8'(report.correctable);
    end
  end
endmodule : aec_rc_model

//--- tb/tb.sv
// Self-checking bench for the error-reporting register slice.
// Assumes the design answers reads one cycle later and reports one cycle after an event.
`timescale 1ns/100ps

module tb;
  import aec_pkg::*;
  typedef struct packed {aec_corr_evt_s c; aec_word_t st; logic rep;} aec_row_s;
  logic          clk_sys, reset, cold_reset, ecrc_err_evt, ur_err_evt;
  logic          unc_mask_ecrc, unc_mask_ur, unc_log_clear, cap_unlock, irq;
  logic          crc_generate_enable, crc_check_enable;
  aec_bus_req_s  bus_req;
  aec_word_t     rd_data;
  aec_corr_evt_s corr_evt;
  aec_report_s   report;
  logic [7:0]    m_f, m_n, m_c;
  int            n_fail, n_compared, cyc, e_f, e_n, e_c;
  aec_row_s      rows [6] = '{'{6'h01, 32'h0000_0001, 1'b1}, '{6'h02, 32'h0000_0040, 1'b1},
                              '{6'h04, 32'h0000_0080, 1'b1}, '{6'h08, 32'h0000_0100, 1'b1},
                              '{6'h10, 32'h0000_1000, 1'b1}, '{6'h20, 32'h0000_2000, 1'b0}};

  aec_top DUT (.clk_sys(clk_sys), .reset(reset), .cold_reset(cold_reset), .bus_req(bus_req),
    .rd_data(rd_data), .corr_evt(corr_evt), .ecrc_err_evt(ecrc_err_evt),
    .ur_err_evt(ur_err_evt), .unc_mask_ecrc(unc_mask_ecrc), .unc_mask_ur(unc_mask_ur),
    .unc_log_clear(unc_log_clear), .cap_unlock(cap_unlock), .report(report),
    .crc_generate_enable(crc_generate_enable), .crc_check_enable(crc_check_enable), .irq(irq));
  aec_rc_model RC (.clk_sys(clk_sys), .cold_reset(cold_reset), .report(report),
    .n_fatal(m_f), .n_nonfatal(m_n), .n_corr(m_c));

  // ==========================================================================
  // Clock, timeout and verdict
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task report_and_stop;
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  // Whole run needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      report_and_stop();
    end
  end

  // ==========================================================================
  // Bus, event and compare helpers
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task wr(input aec_addr_t a, input aec_word_t d);
    @(posedge clk_sys) bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys) bus_req <= '0;
  endtask : wr

  task rd(input aec_addr_t a, input aec_word_t exp, input string nm);
    @(posedge clk_sys) bus_req <= '{a, 32'h0000_0000, 1'b0, 1'b1};
    @(posedge clk_sys) bus_req <= '0;
    #1 chk(nm, rd_data, exp);
  endtask : rd

  // Pulses events for one cycle; the report is looked at in its only cycle
  task ev(input aec_corr_evt_s c, input logic e, input logic u, input logic [2:0] x);
    @(posedge clk_sys);
    corr_evt <= c;
    ecrc_err_evt <= e;
    ur_err_evt <= u;
    @(posedge clk_sys);
    corr_evt <= '0;
    ecrc_err_evt <= 1'b0;
    ur_err_evt <= 1'b0;
    #1 chk("report", 32'(report), 32'(x));
    e_f += int'(x[2]);
    e_n += int'(x[1]);
    e_c += int'(x[0]);
  endtask : ev

  task rst(input logic cold, input int n);
    @(posedge clk_sys);
    reset <= 1'b1;
    cold_reset <= cold;
    repeat (n) @(posedge clk_sys);
    reset <= 1'b0;
    cold_reset <= 1'b0;
    if (cold) {e_f, e_n, e_c} = '0;
  endtask : rst

  task defaults;
    rd(OFS_SEVERITY, 32'h0000_0000, "severity");
    rd(OFS_CORR_STATUS, 32'h0000_0000, "status");
    rd(OFS_CORR_MASK, 32'h0000_2000, "mask");
    rd(OFS_CONTROL, 32'h0000_00A0, "control");
    chk("enables", 32'({crc_generate_enable, crc_check_enable}), 32'h0000_0000);
  endtask : defaults

  task unc_clear;
    @(posedge clk_sys) unc_log_clear <= 1'b1;
    @(posedge clk_sys) unc_log_clear <= 1'b0;
  endtask : unc_clear

  // ==========================================================================
  // Main sequence
  initial begin
    {reset, cold_reset} = 2'b11;
    {ecrc_err_evt, ur_err_evt, unc_mask_ecrc, unc_mask_ur, unc_log_clear, cap_unlock} = '0;
    bus_req = '0;
    corr_evt = '0;
    rst(1'b1, 9);
    defaults();
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      ev(rows[i].c, 1'b0, 1'b0, {2'b00, rows[i].rep});
      rd(OFS_CORR_STATUS, rows[i].st, "status");
      wr(OFS_CORR_STATUS, rows[i].st);
      rd(OFS_CORR_STATUS, 32'h0000_0000, "status");
    end
    $display("test correctable table done");
    // Event in the same cycle as its clear must stay set
    @(posedge clk_sys);
    corr_evt <= 6'h09;
    bus_req <= '{OFS_CORR_STATUS, 32'h0000_0101, 1'b1, 1'b0};
    @(posedge clk_sys);
    corr_evt <= '0;
    bus_req <= '0;
    #1 chk("report", 32'(report), 32'h0000_0001);
    e_c++;
    rd(OFS_CORR_STATUS, 32'h0000_0101, "status");
    wr(OFS_CORR_STATUS, 32'h0000_0101);
    $display("test clear race done");
    wr(OFS_SEVERITY, 32'h0010_0000);
    ev('0, 1'b1, 1'b0, 3'b010);
    rd(OFS_CONTROL, 32'h0000_00B3, "pointer");
    ev('0, 1'b0, 1'b1, 3'b100);
    rd(OFS_CONTROL, 32'h0000_00B3, "pointer");
    unc_clear();
    ev('0, 1'b0, 1'b1, 3'b100);
    rd(OFS_CONTROL, 32'h0000_00B4, "pointer");
    wr(OFS_SEVERITY, 32'h0008_0000);
    ev('0, 1'b0, 1'b1, 3'b010);
    wr(OFS_SEVERITY, 32'hFFFF_FFFF);
    rd(OFS_SEVERITY, 32'h0018_0000, "severity");
    ev('0, 1'b1, 1'b0, 3'b100);
    // Re-armed pointer must ignore masked events
    unc_clear();
    @(posedge clk_sys) {unc_mask_ecrc, unc_mask_ur} <= 2'b11;
    ev('0, 1'b1, 1'b1, 3'b000);
    rd(OFS_CONTROL, 32'h0000_00B4, "pointer");
    @(posedge clk_sys) {unc_mask_ecrc, unc_mask_ur} <= 2'b00;
    $display("test uncorrectable done");
    wr(OFS_CORR_MASK, 32'hFFFF_FFFF);
    rd(OFS_CORR_MASK, 32'h0000_31C1, "mask");
    ev(6'h01, 1'b0, 1'b0, 3'b000);
    rd(OFS_CORR_STATUS, 32'h0000_0001, "status");
    wr(OFS_CORR_MASK, 32'h0000_0000);
    $display("test mask done");
    wr(OFS_CONTROL, 32'hFFFF_FFFF);
    rd(OFS_CONTROL, 32'h0000_01F4, "control");
    chk("enables", 32'({crc_generate_enable, crc_check_enable}), 32'h0000_0003);
    @(posedge clk_sys) cap_unlock <= 1'b1;
    wr(OFS_CONTROL, 32'h0000_0140);
    cap_unlock <= 1'b0;
    rd(OFS_CONTROL, 32'h0000_0154, "control");
    rst(1'b0, 3);
    rd(OFS_CONTROL, 32'h0000_01F4, "control");
    rd(OFS_CORR_STATUS, 32'h0000_0001, "status");
    rd(OFS_SEVERITY, 32'h0018_0000, "severity");
    $display("test control and warm reset done");
    wr(OFS_IRQ_ENABLE, 32'h0000_0001);
    ev(6'h02, 1'b0, 1'b0, 3'b001);
    @(posedge clk_sys) #1 chk("irq", 32'(irq), 32'h0000_0001);
    rd(OFS_IRQ_STATUS, 32'h0000_0001, "irq_status");
    wr(OFS_IRQ_CLEAR, 32'h0000_0001);
    #1 chk("irq", 32'(irq), 32'h0000_0000);
    wr(OFS_IRQ_ENABLE, 32'h0000_0000);
    ev(6'h02, 1'b0, 1'b0, 3'b001);
    @(posedge clk_sys) #1 chk("irq", 32'(irq), 32'h0000_0000);
    rd(OFS_IRQ_STATUS, 32'h0000_0001, "irq_status");
    rd(OFS_IRQ_CLEAR, 32'h0000_0000, "irq_clear");
    rd(12'h200, 32'h0000_0000, "unmapped");
    $display("test interrupt done");
    chk("rc_fatal", 32'(m_f), 32'(e_f));
    chk("rc_nonfatal", 32'(m_n), 32'(e_n));
    chk("rc_corr", 32'(m_c), 32'(e_c));
    rst(1'b1, 3);
    defaults();
    $display("test cold reset done");
    report_and_stop();
  end
endmodule : tb
